// ==== verilog/spvp_pkg.sv ====
// package: constants and carrier types for the serial program/verify port
package spvp_pkg;
    // ==========================================================================
    // widths
    localparam int CMD_W = 6;
    localparam int WORD_W = 14;
    localparam int MEM_W = 12;
    localparam int ADDR_W = 10;
    localparam int USER_WORDS = 512;
    localparam int ID_WORDS = 4;

    // ==========================================================================
    // memory map
    localparam logic [ADDR_W-1:0] CFG_ADDR = 10'h3ff;
    localparam logic [ADDR_W-1:0] USER_LAST = 10'h1ff;
    localparam logic [ADDR_W-1:0] ID_FIRST = 10'h200;
    localparam logic [ADDR_W-1:0] ID_LAST = 10'h203;
    localparam logic [ADDR_W-1:0] PROT_LAST = 10'h03f;
    localparam logic [ADDR_W-1:0] ADDR_ONE = 10'h001;
    localparam int CP_BIT = 3;
    localparam logic [MEM_W-1:0] ERASED_WORD = 12'hfff;
    localparam logic [MEM_W-1:0] ZERO_WORD = 12'h000;

    // ==========================================================================
    // command codes, low four bits of the six-bit command
    localparam logic [3:0] CODE_LOAD = 4'h2;
    localparam logic [3:0] CODE_READ = 4'h4;
    localparam logic [3:0] CODE_INC = 4'h6;
    localparam logic [3:0] CODE_BEGIN = 4'h8;
    localparam logic [3:0] CODE_END = 4'he;
    localparam logic [3:0] CODE_ERASE = 4'h9;

    // ==========================================================================
    // serial framing counts (falling edges already seen in the frame)
    localparam logic [3:0] CMD_LAST_CNT = 4'h5;
    localparam logic [3:0] START_CNT = 4'h0;
    localparam logic [3:0] FIRST_BIT_CNT = 4'h1;
    localparam logic [3:0] LAST_BIT_CNT = 4'he;
    localparam logic [3:0] STOP_CNT = 4'hf;
    localparam logic [3:0] CNT_ONE = 4'h1;

    typedef enum logic [2:0] {OP_NONE, OP_LOAD, OP_READ, OP_INC, OP_BEGIN, OP_END, OP_ERASE} spvp_op_t;
    typedef enum logic [0:0] {ST_IDLE, ST_ERASE} spvp_state_t;

    // words handed from the link domain to the core domain
    typedef struct packed {
        logic [CMD_W-1:0] cmd;
        logic [WORD_W-1:0] word;
    } spvp_link_t;
endpackage

// ==== verilog/spvp_link.sv ====
// serial framing logic on the programmer's clock
`timescale 1ns/1ps
`default_nettype none
module spvp_link (
    input wire logic prog_clk,                    // serial_prog_clock from programmer
    input wire logic rst_n,                       // held low outside program mode
    input wire logic data_i,                      // serial_prog_data pin level
    input wire logic [spvp_pkg::WORD_W-1:0] rd_word, // word to send, quasi-static
    output logic data_o,                          // serial_prog_data output
    output logic data_oe,                         // high while driving the pin
    output spvp_pkg::spvp_link_t link_bus,        // last command and loaded word
    output logic cmd_tgl,                         // flips per command received
    output logic load_tgl                         // flips per load segment done
);
    logic in_data_ff;
    logic seg_read_ff;
    logic [3:0] cnt_ff;
    logic [spvp_pkg::CMD_W-1:0] cmd_sh_ff;
    logic [spvp_pkg::WORD_W-1:0] word_sh_ff;
    logic [spvp_pkg::WORD_W-1:0] rd_sh_ff;
    logic [spvp_pkg::CMD_W-1:0] nxt_cmd;

    assign nxt_cmd = {data_i, cmd_sh_ff[spvp_pkg::CMD_W-1:1]};

    // ==========================================================================
    // falling-edge capture: commands and load data
    always_ff @(negedge prog_clk or negedge rst_n) begin
        if (!rst_n) begin
            in_data_ff <= 1'b0;
            seg_read_ff <= 1'b0;
            cnt_ff <= 4'h0;
            cmd_sh_ff <= '0;
            word_sh_ff <= '0;
            link_bus <= '0;
            cmd_tgl <= 1'b0;
            load_tgl <= 1'b0;
        end else if (!in_data_ff) begin
            cmd_sh_ff <= nxt_cmd;                 // lsb first
            if (cnt_ff == spvp_pkg::CMD_LAST_CNT) begin
                cnt_ff <= 4'h0;
                link_bus.cmd <= nxt_cmd;
                cmd_tgl <= ~cmd_tgl;
                // only load and read carry a data segment
                if (nxt_cmd[3:0] == spvp_pkg::CODE_LOAD || nxt_cmd[3:0] == spvp_pkg::CODE_READ) begin
                    in_data_ff <= 1'b1;
                    seg_read_ff <= (nxt_cmd[3:0] == spvp_pkg::CODE_READ);
                end
            end else begin
                cnt_ff <= cnt_ff + spvp_pkg::CNT_ONE;
            end
        end else begin
            // start and stop clocks ignore the pin
            if (cnt_ff >= spvp_pkg::FIRST_BIT_CNT && cnt_ff <= spvp_pkg::LAST_BIT_CNT) begin
                word_sh_ff <= {data_i, word_sh_ff[spvp_pkg::WORD_W-1:1]};
            end
            if (cnt_ff == spvp_pkg::STOP_CNT) begin
                cnt_ff <= 4'h0;
                in_data_ff <= 1'b0;
                if (!seg_read_ff) begin
                    link_bus.word <= word_sh_ff;
                    load_tgl <= ~load_tgl;
                end
            end else begin
                cnt_ff <= cnt_ff + spvp_pkg::CNT_ONE;
            end
        end
    end

    // ==========================================================================
    // rising-edge drive during a read segment
    // rd_word has stood still since the command gap, so the start edge may take it
    always_ff @(posedge prog_clk or negedge rst_n) begin
        if (!rst_n) begin
            data_o <= 1'b0;
            data_oe <= 1'b0;
            rd_sh_ff <= '0;
        end else if (in_data_ff && seg_read_ff) begin
            if (cnt_ff == spvp_pkg::START_CNT) begin
                rd_sh_ff <= rd_word;
                data_oe <= 1'b0;
            end else if (cnt_ff <= spvp_pkg::LAST_BIT_CNT) begin
                data_oe <= 1'b1;                  // second clock onward
                data_o <= rd_sh_ff[0];
                rd_sh_ff <= rd_sh_ff >> 1;
            end else begin
                data_oe <= 1'b0;                  // first edge of stop
            end
        end else begin
            data_oe <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ==== verilog/spvp_core.sv ====
// serial program/verify port: mode control, address counter and memory
`timescale 1ns/1ps
`default_nettype none
module spvp_core (
    input wire logic CLK,                         // core clock, 20 MHz
    input wire logic RESETN,                      // async reset, active low
    input wire logic HV_SELECT,                   // high_voltage_select_pin, pin level
    input wire logic PROG_CLK,                    // serial_prog_clock from programmer
    input wire logic PROG_DATA_I,                 // serial_prog_data input level
    output logic PROG_DATA_O,                     // serial_prog_data output level
    output logic PROG_DATA_OE,                    // high while driving serial_prog_data
    output logic PROG_MODE,                       // program/verify mode active
    output logic OTHER_RESET_N,                   // reset to the rest of the device
    output logic PROG_HV,                         // cells under programming voltage
    output logic ERASE_BUSY                       // bulk erase in progress
);
    // ==========================================================================
    // declarations
    logic hv_s1_ff, hv_s2_ff;
    logic [1:0] tgl_s1_ff, tgl_s2_ff, tgl_s3_ff;
    logic mode_ff;
    logic link_rst_n_ff;
    logic [spvp_pkg::ADDR_W-1:0] addr_ff;
    logic cfg_ok_ff;
    logic [spvp_pkg::MEM_W-1:0] load_word_ff;
    logic [spvp_pkg::MEM_W-1:0] cfg_word_ff;
    logic [spvp_pkg::WORD_W-1:0] rd_word_ff;
    logic erase_ids_ff;
    logic [8:0] erase_idx_ff;
    spvp_pkg::spvp_state_t state_ff;
    // user words, then the id words
    logic [spvp_pkg::MEM_W-1:0] user_mem [spvp_pkg::USER_WORDS];
    logic [spvp_pkg::MEM_W-1:0] id_mem [spvp_pkg::ID_WORDS];
    spvp_pkg::spvp_link_t link_bus;
    logic cmd_tgl, load_tgl;
    logic live;
    logic cmd_evt, load_evt;
    spvp_pkg::spvp_op_t op;
    logic [spvp_pkg::MEM_W-1:0] rd_val;
    logic in_user, in_id, at_cfg, writable, erase_ok;

    // command decoding, top two bits are don't care
    // unlisted codes do nothing
    function automatic spvp_pkg::spvp_op_t decode_op(input logic [spvp_pkg::CMD_W-1:0] cmd);
        case (cmd[3:0])
            spvp_pkg::CODE_LOAD: decode_op = spvp_pkg::OP_LOAD;
            spvp_pkg::CODE_READ: decode_op = spvp_pkg::OP_READ;
            spvp_pkg::CODE_INC: decode_op = spvp_pkg::OP_INC;
            spvp_pkg::CODE_BEGIN: decode_op = spvp_pkg::OP_BEGIN;
            spvp_pkg::CODE_END: decode_op = spvp_pkg::OP_END;
            spvp_pkg::CODE_ERASE: decode_op = spvp_pkg::OP_ERASE;
            default: decode_op = spvp_pkg::OP_NONE;
        endcase
    endfunction

    // first id word: an erase target
    function automatic logic is_id_first(input logic [spvp_pkg::ADDR_W-1:0] a);
        is_id_first = (a == spvp_pkg::ID_FIRST);
    endfunction

    // ==========================================================================
    // serial link on the programmer's clock
    // its reset moves only while that clock stands low, before the first frame
    // buses stand still over the gap,
    // so only the toggles need syncing
    spvp_link u_link (
        .prog_clk(PROG_CLK),
        .rst_n(link_rst_n_ff),
        .data_i(PROG_DATA_I),
        .rd_word(rd_word_ff),
        .data_o(PROG_DATA_O),
        .data_oe(PROG_DATA_OE),
        .link_bus(link_bus),
        .cmd_tgl(cmd_tgl),
        .load_tgl(load_tgl)
    );

    // ==========================================================================
    // synchronisers: mode pin and the two event toggles
    // toggles, as a pulse could be lost
    // only stage two reads stage one
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            hv_s1_ff <= 1'b0;
            hv_s2_ff <= 1'b0;
            tgl_s1_ff <= 2'b00;
            tgl_s2_ff <= 2'b00;
            tgl_s3_ff <= 2'b00;
        end else begin
            hv_s1_ff <= HV_SELECT;
            hv_s2_ff <= hv_s1_ff;
            tgl_s1_ff <= {load_tgl, cmd_tgl};
            tgl_s2_ff <= tgl_s1_ff;
            tgl_s3_ff <= tgl_s2_ff;
        end
    end

    // events count only while the mode holds; a link reset flip is dropped
    // commands during erase are dropped
    assign live = mode_ff & hv_s2_ff;
    assign cmd_evt = live & (tgl_s2_ff[0] ^ tgl_s3_ff[0]) & (state_ff == spvp_pkg::ST_IDLE);
    assign load_evt = live & (tgl_s2_ff[1] ^ tgl_s3_ff[1]);
    assign op = cmd_evt ? decode_op(link_bus.cmd) : spvp_pkg::OP_NONE;

    // ==========================================================================
    // mode control; the programmer enters with clock and data low
    // rest of device held while in mode
    // link restarts empty on each entry
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            mode_ff <= 1'b0;
            link_rst_n_ff <= 1'b0;
            OTHER_RESET_N <= 1'b1;
            PROG_MODE <= 1'b0;
        end else begin
            mode_ff <= hv_s2_ff;
            link_rst_n_ff <= hv_s2_ff;            // fresh framing on every entry
            OTHER_RESET_N <= ~hv_s2_ff;
            PROG_MODE <= hv_s2_ff;
        end
    end

    // ==========================================================================
    // address counter
    // entry wins over a stale increment
    // no decrement; top wraps by overflow
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            addr_ff <= spvp_pkg::CFG_ADDR;
            cfg_ok_ff <= 1'b1;
        end else if (hv_s2_ff && !mode_ff) begin
            addr_ff <= spvp_pkg::CFG_ADDR;
            cfg_ok_ff <= 1'b1;
        end else if (op == spvp_pkg::OP_INC) begin
            addr_ff <= addr_ff + spvp_pkg::ADDR_ONE; // up only, 0x1ff to 0x200
            cfg_ok_ff <= 1'b0;
        end
    end

    // ==========================================================================
    // loaded word, two top bits dropped
    // kept until the next load
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            load_word_ff <= spvp_pkg::ERASED_WORD;
        end else if (load_evt) begin
            load_word_ff <= link_bus.word[spvp_pkg::MEM_W-1:0];
        end
    end

    // ==========================================================================
    // address decode of the current location
    // only four id words answer
    // erase only at config or first id
    assign in_user = (addr_ff <= spvp_pkg::USER_LAST);
    assign in_id = (addr_ff >= spvp_pkg::ID_FIRST) && (addr_ff <= spvp_pkg::ID_LAST);
    assign at_cfg = (addr_ff == spvp_pkg::CFG_ADDR) && cfg_ok_ff;
    assign writable = in_user | in_id | at_cfg;
    assign erase_ok = at_cfg | is_id_first(addr_ff);

    // read value; reserved and hidden locations give zero
    // default keeps it latch-free
    always_comb begin
        rd_val = spvp_pkg::ZERO_WORD;
        if (in_user) begin
            // protection covers program memory above the first block only
            if (cfg_word_ff[spvp_pkg::CP_BIT] || addr_ff <= spvp_pkg::PROT_LAST) begin
                rd_val = user_mem[addr_ff[8:0]];
            end else begin
                rd_val = spvp_pkg::ZERO_WORD;
            end
        end else if (in_id) begin
            rd_val = id_mem[addr_ff[1:0]];        // never protected
        end else if (at_cfg) begin
            rd_val = cfg_word_ff;
        end
    end

    // ==========================================================================
    // read word handed to the link, top bits zero
    // taken at the command, so it is
    // settled long before the segment
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            rd_word_ff <= '0;
        end else if (op == spvp_pkg::OP_READ) begin
            rd_word_ff <= {2'b00, rd_val};
        end
    end

    // ==========================================================================
    // programming voltage: on at begin, off at end
    // the pulse length is the programmer's; the write lands when it ends
    // a lost end holds it until exit
    // begin without a load is not blocked
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            PROG_HV <= 1'b0;
        end else if (!live) begin
            PROG_HV <= 1'b0;                      // leaving the mode also discharges
        end else if (op == spvp_pkg::OP_BEGIN) begin
            PROG_HV <= 1'b1;
        end else if (op == spvp_pkg::OP_END) begin
            PROG_HV <= 1'b0;
        end
    end

    // ==========================================================================
    // bulk erase sequencer, one word per cycle
    // 512 cycles is far inside the erase time the programmer waits
    // ids clear in the first four steps of an erase started at the first id word
    // commands blocked until the end
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            state_ff <= spvp_pkg::ST_IDLE;
            erase_idx_ff <= 9'h000;
            erase_ids_ff <= 1'b0;
            ERASE_BUSY <= 1'b0;
        end else begin
            case (state_ff)
                spvp_pkg::ST_IDLE: begin
                    if (op == spvp_pkg::OP_ERASE && erase_ok) begin
                        state_ff <= spvp_pkg::ST_ERASE;
                        erase_idx_ff <= 9'h000;
                        erase_ids_ff <= is_id_first(addr_ff);
                        ERASE_BUSY <= 1'b1;
                    end
                end
                spvp_pkg::ST_ERASE: begin
                    erase_idx_ff <= erase_idx_ff + 9'h001;
                    if (erase_idx_ff == spvp_pkg::USER_LAST[8:0]) begin
                        state_ff <= spvp_pkg::ST_IDLE;
                        ERASE_BUSY <= 1'b0;
                    end
                end
                default: begin
                    state_ff <= spvp_pkg::ST_IDLE;
                    ERASE_BUSY <= 1'b0;
                end
            endcase
        end
    end

    // ==========================================================================
    // configuration word: programs like memory, erased by bulk erase
    // only bulk erase or RESETN clears protection
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            cfg_word_ff <= spvp_pkg::ERASED_WORD;
        end else if (op == spvp_pkg::OP_ERASE && erase_ok && state_ff == spvp_pkg::ST_IDLE) begin
            cfg_word_ff <= spvp_pkg::ERASED_WORD;
        end else if (op == spvp_pkg::OP_END && PROG_HV && at_cfg) begin
            cfg_word_ff <= cfg_word_ff & load_word_ff; // no erase
        end
    end

    // ==========================================================================
    // memory arrays: programming only clears bits, erase sets them
    // no reset: undefined until erased
    // writes need a prior begin
    always_ff @(posedge CLK) begin
        if (state_ff == spvp_pkg::ST_ERASE) begin
            user_mem[erase_idx_ff] <= spvp_pkg::ERASED_WORD;
            if (erase_ids_ff && erase_idx_ff < 9'(spvp_pkg::ID_WORDS)) begin
                id_mem[erase_idx_ff[1:0]] <= spvp_pkg::ERASED_WORD;
            end
        end else if (op == spvp_pkg::OP_END && PROG_HV && writable) begin
            if (in_user) begin
                user_mem[addr_ff[8:0]] <= user_mem[addr_ff[8:0]] & load_word_ff;
            end else if (in_id) begin
                id_mem[addr_ff[1:0]] <= id_mem[addr_ff[1:0]] & load_word_ff;
            end
        end
    end
endmodule
`default_nettype wire

// ==== test/spvp_core_asserts.sv ====
// checker: port-level properties of the serial program/verify port
`timescale 1ns/1ps
`default_nettype none
module spvp_core_checker (
    input wire logic CLK, // core clock
    input wire logic RESETN, // async reset
    input wire logic HV_SELECT, // mode select pin
    input wire logic PROG_CLK, // serial clock
    input wire logic PROG_DATA_I, // data in
    input wire logic PROG_DATA_O, // data out
    input wire logic PROG_DATA_OE, // data enable
    input wire logic PROG_MODE, // mode active
    input wire logic OTHER_RESET_N, // rest of device
    input wire logic PROG_HV, // cell voltage
    input wire logic ERASE_BUSY // erase running
);
    logic [9:0] busy_cnt_ff;
    logic [9:0] nxt_busy_cnt;
    // ==========================================================================
    // length of the current erase run, in core cycles
    assign nxt_busy_cnt = ERASE_BUSY ? busy_cnt_ff + 10'h001 : 10'h000;
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            busy_cnt_ff <= 10'h000;
        end else begin
            busy_cnt_ff <= nxt_busy_cnt;
        end
    end
    // ==========================================================================
    // properties; sync stages give three core edges of slack on the select pin
    property p_entry;
        @(posedge CLK) disable iff (!RESETN) $rose(HV_SELECT) |-> ##[1:5] PROG_MODE;
    endproperty
    a_entry: assert property (p_entry) else $error("mode not entered");
    property p_other_rst;
        @(posedge CLK) disable iff (!RESETN) PROG_MODE && $past(PROG_MODE) |-> !OTHER_RESET_N;
    endproperty
    a_other_rst: assert property (p_other_rst) else $error("rest of device not held");
    property p_exit;
        @(posedge CLK) disable iff (!RESETN) !HV_SELECT [*4] |-> !PROG_MODE && OTHER_RESET_N && !PROG_HV;
    endproperty
    a_exit: assert property (p_exit) else $error("mode outputs stuck after exit");
    property p_oe_idle;
        @(posedge CLK) disable iff (!RESETN) !PROG_MODE [*3] |-> !PROG_DATA_OE;
    endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("data pin driven outside mode");
    // the pin is driven from the second to the sixteenth rising edge
    property p_oe_len;
        @(posedge PROG_CLK) disable iff (!RESETN)
            $rose(PROG_DATA_OE) |-> PROG_DATA_OE [*8] ##1 PROG_DATA_OE [*6] ##1 !PROG_DATA_OE;
    endproperty
    a_oe_len: assert property (p_oe_len) else $error("read drive window wrong");
    property p_erase_len;
        @(posedge CLK) disable iff (!RESETN) $fell(ERASE_BUSY) |-> busy_cnt_ff == 10'h200;
    endproperty
    a_erase_len: assert property (p_erase_len) else $error("erase length wrong");
    property p_hv_rise;
        @(posedge CLK) disable iff (!RESETN) $rose(PROG_HV) |-> !ERASE_BUSY && PROG_MODE;
    endproperty
    a_hv_rise: assert property (p_hv_rise) else $error("voltage raised while busy");
    property p_busy_mode;
        @(posedge CLK) disable iff (!RESETN) ERASE_BUSY |-> PROG_MODE && !PROG_HV;
    endproperty
    a_busy_mode: assert property (p_busy_mode) else $error("erase outside mode");
    // link sits in reset outside the mode, output parked low
    property p_dout_idle;
        @(posedge CLK) disable iff (!RESETN) !PROG_MODE [*3] |-> !PROG_DATA_O;
    endproperty
    a_dout_idle: assert property (p_dout_idle) else $error("data output not parked");
endmodule
bind spvp_core spvp_core_checker u_checker (.CLK(CLK), .RESETN(RESETN), .HV_SELECT(HV_SELECT), .PROG_CLK(PROG_CLK),
    .PROG_DATA_I(PROG_DATA_I), .PROG_DATA_O(PROG_DATA_O), .PROG_DATA_OE(PROG_DATA_OE), .PROG_MODE(PROG_MODE),
    .OTHER_RESET_N(OTHER_RESET_N), .PROG_HV(PROG_HV), .ERASE_BUSY(ERASE_BUSY));
`default_nettype wire

// ==== test/spvp_prog_model.sv ====
// programmer model: serial clock and data for the port
`timescale 1ns/1ps
`default_nettype none
module spvp_prog_model (
    output logic prog_clk, // serial clock, still between frames
    output logic data_drv, // level offered to the data wire
    input wire logic data_pin // resolved data wire
);
    localparam int HALF = 6;
    localparam int GAP = 1050;
    // ==========================================================================
    // clock and data low from time zero
    initial begin
        prog_clk = 1'b0;
        data_drv = 1'b0;
    end
    // one clock: data moves half a period after the fall, sampled before it
    task automatic clk_bit(input logic d, output logic s);
        data_drv = d;
        #(HALF) prog_clk = 1'b1;
        #(HALF - 1) s = data_pin;
        #1 prog_clk = 1'b0;
        #(HALF);
    endtask
    // data held low before the select pin rises
    task automatic idle_low;
        data_drv = 1'b0;
    endtask
    // six clocks, lsb first, then the gap
    task automatic send_cmd(input logic [5:0] code);
        logic s;
        for (int i = 0; i < 6; i++) begin
            clk_bit(code[i], s);
        end
        data_drv = ~code[5];
        #(GAP);
    endtask
    // start, 14 bits lsb first, stop; on reads w is what a released wire shows
    task automatic xfer(input logic [13:0] w, output logic [13:0] r);
        logic s;
        clk_bit(~w[0], s);
        for (int i = 0; i < 14; i++) begin
            clk_bit(w[i], s);
            r[i] = s;
        end
        clk_bit(~w[13], s);
        data_drv = ~w[13];
        #(GAP);
    endtask
endmodule
`default_nettype wire

// ==== test/spvp_core_tb.sv ====
// testbench: serial program/verify port against a programmer model
`timescale 1ns/1ps
`default_nettype none
module spvp_core_tb;
    localparam int LIMIT = 100000;
    logic clk, resetn, hv_select, prog_clk, data_drv, data_o, data_oe;
    logic prog_mode, other_reset_n, prog_hv, erase_busy;
    wire logic data_pin;
    int n_fail = 0;
    int cmp_count = 0;
    int cyc = 0;
    // ==========================================================================
    // the device wins the wire while it drives
    assign data_pin = data_oe ? data_o : data_drv;
    spvp_core uut (.CLK(clk), .RESETN(resetn), .HV_SELECT(hv_select), .PROG_CLK(prog_clk), .PROG_DATA_I(data_pin),
        .PROG_DATA_O(data_o), .PROG_DATA_OE(data_oe), .PROG_MODE(prog_mode), .OTHER_RESET_N(other_reset_n),
        .PROG_HV(prog_hv), .ERASE_BUSY(erase_busy));
    spvp_prog_model prog (.prog_clk(prog_clk), .data_drv(data_drv), .data_pin(data_pin));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            n_fail++;
            $display("unexpected cycles: expected below %0d seen %0d", LIMIT, cyc);
            print_verdict();
        end
    end
    // ==========================================================================
    // shared tasks
    task automatic check(input string what, input logic [13:0] exp, input logic [13:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic read_word(input logic [13:0] exp);
        logic [13:0] got;
        prog.send_cmd(6'h04);
        prog.xfer(14'h2aaa, got);
        check("read word", exp, got);
    endtask
    // top two command bits toggled on purpose
    task automatic inc_n(input int n);
        for (int i = 0; i < n; i++) begin
            prog.send_cmd(i[0] ? 6'h36 : 6'h06);
        end
    endtask
    task automatic bulk_erase(input logic [5:0] code);
        int k;
        prog.send_cmd(code);
        @(negedge clk);
        check("erase busy", 14'h0001, {13'h0000, erase_busy});
        k = 0;
        while (erase_busy !== 1'b0 && k < 700) begin
            @(negedge clk);
            k++;
        end
        check("erase done", 14'h0000, {13'h0000, erase_busy});
    endtask
    task automatic set_mode(input logic on);
        prog.idle_low();
        @(posedge clk);
        hv_select <= on;
        repeat (20) @(posedge clk);
        @(negedge clk);
        check("mode", {13'h0000, on}, {13'h0000, prog_mode});
        check("other reset", {13'h0000, ~on}, {13'h0000, other_reset_n});
    endtask
    // ==========================================================================
    // walk to the id words, erase them, look at reserved space
    task automatic t_id_erase;
        set_mode(1'b1);
        read_word(14'h0fff);
        inc_n(513);
        bulk_erase(6'h09);
        read_word(14'h0fff);
        inc_n(4);
        read_word(14'h0000);
        set_mode(1'b0);
    endtask
    // mid-run reset with the pin high; entry follows release
    task automatic t_reset;
        set_mode(1'b1);
        inc_n(1);
        @(posedge clk);
        resetn <= 1'b0;
        prog.idle_low();
        repeat (10) @(posedge clk);
        check("reset mode", 14'h0000, {13'h0000, prog_mode});
        resetn <= 1'b1;
        repeat (20) @(posedge clk);
        @(negedge clk);
        check("mode again", 14'h0001, {13'h0000, prog_mode});
        read_word(14'h0fff);
        set_mode(1'b0);
    endtask
    // program the configuration word with protection on, then walk the map
    task automatic t_protect;
        logic [13:0] unused;
        set_mode(1'b1);
        bulk_erase(6'h39);
        read_word(14'h0fff);
        prog.send_cmd(6'h02);
        prog.xfer(14'h3ff7, unused);
        prog.send_cmd(6'h08);
        @(negedge clk);
        check("voltage on", 14'h0001, {13'h0000, prog_hv});
        repeat (40000) @(posedge clk);
        prog.send_cmd(6'h0e);
        @(negedge clk);
        check("voltage off", 14'h0000, {13'h0000, prog_hv});
        repeat (2000) @(posedge clk);
        read_word(14'h0ff7);
        prog.send_cmd(6'h03);
        prog.send_cmd(6'h0f);
        read_word(14'h0ff7);
        inc_n(64);
        read_word(14'h0fff);
        inc_n(1);
        read_word(14'h0000);
        inc_n(448);
        read_word(14'h0fff);
        inc_n(511);
        read_word(14'h0000);
        inc_n(1);
        read_word(14'h0fff);
        set_mode(1'b0);
    endtask
    // ==========================================================================
    // main sequence
    initial begin
        resetn = 1'b0;
        hv_select = 1'b0;
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        repeat (5) @(posedge clk);
        t_id_erase();
        t_reset();
        t_protect();
        print_verdict();
    end
endmodule
`default_nettype wire
